// ---- common/ucd_pkg.sv ----
// Constants and types shared by the USB device command decoder.
package ucd_pkg;
  // Command codes; endpoint-indexed groups give the code of endpoint slot 0.
  localparam logic [7:0] CMD_EPCFG_WR = 8'h20;
  localparam logic [7:0] CMD_EPCFG_RD = 8'h30;
  localparam logic [7:0] CMD_VALIDATE = 8'h60;
  localparam logic [7:0] CMD_CLEAR = 8'h70;
  localparam logic [7:0] CMD_ERRCODE = 8'ha0;
  localparam logic [7:0] CMD_UNLOCK = 8'hb0;
  localparam logic [7:0] CMD_SCRATCH_WR = 8'hb2;
  localparam logic [7:0] CMD_SCRATCH_RD = 8'hb3;
  localparam logic [7:0] CMD_FRAME_RD = 8'hb4;
  localparam logic [7:0] CMD_ADDR_WR = 8'hb6;
  localparam logic [7:0] CMD_ADDR_RD = 8'hb7;
  localparam logic [7:0] CMD_MODE_WR = 8'hb8;
  localparam logic [7:0] CMD_MODE_RD = 8'hb9;
  localparam logic [7:0] CMD_INT_RD = 8'hc0;
  localparam logic [7:0] CMD_STATUS_IMG = 8'hd0;
  localparam logic [7:0] CMD_SETUP_ACK = 8'hf4;

  // Field positions of the endpoint setup, address and mode bytes.
  localparam int EP_ENABLE_BIT = 7;
  localparam int EP_DIR_BIT = 6;
  localparam int EP_DBL_BIT = 5;
  localparam int EP_ISO_BIT = 4;
  localparam int EP_SIZE_MSB = 3;
  localparam int ADDR_ENABLE_BIT = 7;
  localparam int ADDR_FIELD_MSB = 6;
  localparam int MODE_DEBUG_BIT = 2;

  // Reset values.
  localparam logic [7:0] EP_SETUP_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] SCRATCH_RST = 16'h0000;
  localparam logic [6:0] BUS_RESET_ADDR = 7'h00;

  localparam int NUM_EP = 16;
  localparam logic [3:0] LAST_EP = 4'hf;

  // Completion times; the slow figure applies to slow commands in 8-bit mode.
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAST_DONE_NS = 80;
  localparam int SLOW_DONE_NS = 600;
  localparam int FAST_DONE_CYC =
    (FAST_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_DONE_CYC =
    (SLOW_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } ucd_state_e;
endpackage

// ---- logic/ucd_command_decoder.sv ----
// Command decoder and initialization registers of a USB device controller.
module ucd_command_decoder
  import ucd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_strobe,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [15:0] data_in,
  input wire logic bus_wide,
  input wire logic usb_bus_reset,
  input wire logic zlp_acked,
  input wire logic lock_request,
  input wire logic nak_event,
  input wire logic error_event,
  input wire logic [127:0] ep_status_flat,
  input wire logic [127:0] err_code_flat,
  input wire logic [10:0] frame_number,
  input wire logic [31:0] irq_flags,
  output logic [15:0] data_out,
  output logic [127:0] ep_setup_flat,
  output logic [6:0] active_address,
  output logic device_enabled,
  output logic [7:0] mode_bits,
  output logic alloc_start,
  output logic fifo_invalidate,
  output logic setup_ack,
  output logic cmd_busy,
  output logic debug_irq,
  output logic write_locked
);

  function automatic logic [2:0] cmd_len(input logic [7:0] code);
    logic [2:0] n;
    n = 3'd0;
    case (code[7:4])
      4'h2, 4'h3, 4'ha, 4'hd:
        n = 3'd1;
      4'hc:
        n = (code == CMD_INT_RD) ? 3'd4 : 3'd0;
      4'hb:
      begin
        if (code == CMD_UNLOCK || code == CMD_SCRATCH_WR ||
            code == CMD_SCRATCH_RD || code == CMD_FRAME_RD)
          n = 3'd2;
        else if (code >= CMD_ADDR_WR && code <= CMD_MODE_RD)
          n = 3'd1;
        else
          n = 3'd0;
      end
      default:
        n = 3'd0;
    endcase
    return n;
  endfunction

  function automatic logic is_read(input logic [7:0] code);
    return code[7:4] == 4'h3 || code[7:4] == 4'ha || code[7:4] == 4'hd ||
      code == CMD_SCRATCH_RD || code == CMD_FRAME_RD ||
      code == CMD_ADDR_RD || code == CMD_MODE_RD || code == CMD_INT_RD;
  endfunction

  function automatic logic [7:0] byte_of(input logic [31:0] v,
                                         input logic [2:0] idx);
    return v[{idx[1:0], 3'b000} +: 8];
  endfunction

  // Bus pins cross into core_clk through two flops; a third gives edges.
  logic [18:0] pin_s1_q;
  logic [18:0] pin_s2_q;
  logic [2:0] strobe_prev_q;
  logic cmd_ev;
  logic wr_ev;
  logic rd_ev;
  logic [15:0] din;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      strobe_prev_q <= '0;
    end
    else
    begin
      pin_s1_q <= {cmd_strobe, wr_strobe, rd_strobe, data_in};
      pin_s2_q <= pin_s1_q;
      strobe_prev_q <= pin_s2_q[18:16];
    end
  end

  assign cmd_ev = pin_s2_q[18] & ~strobe_prev_q[2];
  assign wr_ev = pin_s2_q[17] & ~strobe_prev_q[1];
  assign rd_ev = pin_s2_q[16] & ~strobe_prev_q[0];
  assign din = pin_s2_q[15:0];

  ucd_state_e state_q;
  logic [7:0] cmd_q;
  logic [2:0] len_q;
  logic [2:0] cnt_q;
  logic [15:0] wr_buf_q;
  logic [31:0] rd_val_q;
  logic [15:0] data_out_q;
  logic [7:0] ep_setup_q [NUM_EP];
  logic [3:0] next_ep_q;
  logic [7:0] addr_q;
  logic [7:0] mode_q;
  logic [15:0] scratch_q;
  logic addr_pending_q;
  logic [6:0] active_addr_q;
  logic dev_en_q;
  logic locked_q;
  logic [9:0] busy_q;
  logic alloc_q;
  logic inval_q;
  logic setup_ack_q;
  logic debug_irq_q;

  // Only the low byte of the command word carries the code.
  logic [7:0] code;
  logic [3:0] code_ep;
  logic [2:0] code_len;
  logic [31:0] rd_src;
  logic [15:0] wr_next;
  logic [2:0] cnt_next;
  logic commit;
  logic [7:0] wr_byte;
  logic [3:0] wr_ep;

  assign code = din[7:0];
  assign code_ep = code[3:0];
  assign code_len = cmd_len(code);
  assign wr_byte = wr_next[7:0];
  assign wr_ep = cmd_q[3:0];

  // Read sources are sampled when the command arrives; status is not cleared.
  always_comb
  begin
    rd_src = 32'h0000_0000;
    case (code[7:4])
      4'h3:
        rd_src = {24'h00_0000, ep_setup_q[code_ep]};
      4'ha:
        rd_src = {24'h00_0000, err_code_flat[{code_ep, 3'b000} +: 8]};
      4'hd:
        rd_src = {24'h00_0000, ep_status_flat[{code_ep, 3'b000} +: 8]};
      default:
      begin
        if (code == CMD_SCRATCH_RD)
          rd_src = {16'h0000, scratch_q};
        else if (code == CMD_FRAME_RD)
          rd_src = {21'h00_0000, frame_number};
        else if (code == CMD_ADDR_RD)
          rd_src = {24'h00_0000, addr_q};
        else if (code == CMD_MODE_RD)
          rd_src = {24'h00_0000, mode_q};
        else if (code == CMD_INT_RD)
          rd_src = irq_flags;
        else
          rd_src = 32'h0000_0000;
      end
    endcase
  end

  // Data bytes arrive low first; a word carries two in 16-bit mode, one in 8-bit mode; an odd spare is dropped.
  always_comb
  begin
    wr_next = wr_buf_q;
    if (cnt_q == 3'd0)
    begin
      wr_next[7:0] = din[7:0];
      if (bus_wide)
        wr_next[15:8] = din[15:8];
    end
    else
    begin
      wr_next[15:8] = din[7:0];
    end
    cnt_next = cnt_q + (bus_wide ? 3'd2 : 3'd1);
  end

  assign commit = wr_ev && state_q == ST_WRITE && cnt_next >= len_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      cmd_q <= 8'h00;
      len_q <= 3'd0;
      cnt_q <= 3'd0;
      wr_buf_q <= 16'h0000;
      rd_val_q <= 32'h0000_0000;
    end
    else if (cmd_ev)
    begin
      cmd_q <= code;
      len_q <= code_len;
      cnt_q <= 3'd0;
      wr_buf_q <= 16'h0000;
      rd_val_q <= rd_src;
      if (code_len == 3'd0)
        state_q <= ST_IDLE;
      else if (is_read(code))
        state_q <= ST_READ;
      else
        state_q <= ST_WRITE;
    end
    else
    begin
      case (state_q)
        ST_WRITE:
        begin
          if (wr_ev)
          begin
            wr_buf_q <= wr_next;
            cnt_q <= cnt_next;
            if (commit)
              state_q <= ST_IDLE;
          end
        end
        ST_READ:
        begin
          if (rd_ev)
          begin
            cnt_q <= cnt_next;
            if (cnt_next >= len_q)
              state_q <= ST_IDLE;
          end
        end
        ST_IDLE:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // The read word is staged before the strobe so it is stable when sampled.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      data_out_q <= 16'h0000;
    else if (cmd_ev)
    begin
      data_out_q[7:0] <= byte_of(rd_src, 3'd0);
      data_out_q[15:8] <= (bus_wide && code_len > 3'd1) ?
        byte_of(rd_src, 3'd1) : 8'h00;
    end
    else if (rd_ev && state_q == ST_READ)
    begin
      data_out_q[7:0] <= byte_of(rd_val_q, cnt_next);
      data_out_q[15:8] <= (bus_wide && cnt_next + 3'd1 < len_q) ?
        byte_of(rd_val_q, cnt_next + 3'd1) : 8'h00;
    end
  end

  // Lock requests win over a finishing unlock in the same cycle.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      locked_q <= 1'b0;
    else if (lock_request)
      locked_q <= 1'b1;
    else if (commit && cmd_q == CMD_UNLOCK)
      locked_q <= 1'b0;
  end

  // Endpoint setup table and in-order configuration tracking.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_EP; i++)
        ep_setup_q[i] <= EP_SETUP_RST;
      next_ep_q <= 4'h0;
      alloc_q <= 1'b0;
      inval_q <= 1'b0;
    end
    else
    begin
      alloc_q <= 1'b0;
      inval_q <= 1'b0;
      if (usb_bus_reset)
      begin
        for (int i = 0; i < NUM_EP; i++)
          ep_setup_q[i][EP_ENABLE_BIT] <= 1'b0;
        next_ep_q <= 4'h0;
      end
      else if (commit && cmd_q[7:4] == CMD_EPCFG_WR[7:4] && !locked_q)
      begin
        ep_setup_q[wr_ep] <= wr_byte;
        if (wr_byte[EP_ENABLE_BIT] != ep_setup_q[wr_ep][EP_ENABLE_BIT] ||
            wr_byte[EP_SIZE_MSB:0] != ep_setup_q[wr_ep][EP_SIZE_MSB:0])
          inval_q <= 1'b1;
        // An out-of-order write restarts the sequence at the control OUT slot.
        if (wr_ep == next_ep_q && wr_ep == LAST_EP)
        begin
          alloc_q <= 1'b1;
          next_ep_q <= 4'h0;
        end
        else if (wr_ep == next_ep_q)
          next_ep_q <= next_ep_q + 4'h1;
        else
          next_ep_q <= (wr_ep == 4'h0) ? 4'h1 : 4'h0;
      end
    end
  end

  // Address, mode and scratch registers; a bus reset leaves them as written.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_q <= ADDR_RST;
      mode_q <= MODE_RST;
      scratch_q <= SCRATCH_RST;
    end
    else if (commit && !locked_q)
    begin
      if (cmd_q == CMD_ADDR_WR)
        addr_q <= wr_byte;
      if (cmd_q == CMD_MODE_WR)
        mode_q <= wr_byte;
      if (cmd_q == CMD_SCRATCH_WR)
        scratch_q <= wr_next;
    end
  end

  // The address in use changes only on bus reset or the acked empty packet.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_pending_q <= 1'b0;
      active_addr_q <= BUS_RESET_ADDR;
      dev_en_q <= 1'b0;
    end
    else if (usb_bus_reset)
    begin
      addr_pending_q <= 1'b0;
      active_addr_q <= BUS_RESET_ADDR;
      dev_en_q <= 1'b1;
    end
    else if (commit && !locked_q && cmd_q == CMD_ADDR_WR)
      addr_pending_q <= 1'b1;
    else if (zlp_acked && addr_pending_q)
    begin
      addr_pending_q <= 1'b0;
      active_addr_q <= addr_q[ADDR_FIELD_MSB:0];
      dev_en_q <= addr_q[ADDR_ENABLE_BIT];
    end
  end

  // Completion timer; slow commands in 8-bit mode hold busy much longer.
  logic zero_cmd;
  logic slow_cmd;
  assign zero_cmd = cmd_ev && code_len == 3'd0;
  assign slow_cmd = (zero_cmd && (code == CMD_SETUP_ACK ||
    code[7:4] == CMD_VALIDATE[7:4] || code[7:4] == CMD_CLEAR[7:4])) ||
    (commit && cmd_q[7:4] == CMD_EPCFG_WR[7:4]);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      busy_q <= 10'd0;
    else if (slow_cmd && !bus_wide)
      busy_q <= 10'(SLOW_DONE_CYC);
    else if (zero_cmd || commit)
      busy_q <= 10'(FAST_DONE_CYC);
    else if (busy_q != 10'd0)
      busy_q <= busy_q - 10'd1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      setup_ack_q <= 1'b0;
      debug_irq_q <= 1'b0;
    end
    else
    begin
      setup_ack_q <= zero_cmd && code == CMD_SETUP_ACK;
      debug_irq_q <= mode_q[MODE_DEBUG_BIT] &&
        (nak_event || error_event);
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_EP; i++)
      ep_setup_flat[i*8 +: 8] = ep_setup_q[i];
  end

  assign data_out = data_out_q;
  assign active_address = active_addr_q;
  assign device_enabled = dev_en_q;
  assign mode_bits = mode_q;
  assign alloc_start = alloc_q;
  assign fifo_invalidate = inval_q;
  assign setup_ack = setup_ack_q;
  assign cmd_busy = busy_q != 10'd0;
  assign debug_irq = debug_irq_q;
  assign write_locked = locked_q;

endmodule

// ---- bench/ucd_properties.sv ----
// Port-level concurrent checks for the USB device command decoder.
module ucd_properties
  import ucd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_strobe,
  input wire logic bus_wide,
  input wire logic usb_bus_reset,
  input wire logic zlp_acked,
  input wire logic lock_request,
  input wire logic nak_event,
  input wire logic error_event,
  input wire logic [127:0] ep_setup_flat,
  input wire logic [6:0] active_address,
  input wire logic device_enabled,
  input wire logic [7:0] mode_bits,
  input wire logic setup_ack,
  input wire logic cmd_busy,
  input wire logic debug_irq,
  input wire logic write_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic [4:0] run_q;
  wire any_en = |(ep_setup_flat & {16{8'h80}});
  // Length of the current busy run, judged only when the run ends.
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      run_q <= 5'h00;
    else
      run_q <= cmd_busy ? run_q + 5'h01 : 5'h00;
  sequence s_slow_ack;
    setup_ack && !bus_wide;
  endsequence
  sequence s_debug_event;
    mode_bits[MODE_DEBUG_BIT] && (nak_event || error_event);
  endsequence
  AST_SLOW_ACK: assert property (s_slow_ack |-> cmd_busy [*8])
    else $error("setup ack busy too short");
  AST_BUSY_LEN: assert property ($fell(cmd_busy) |->
    run_q == FAST_DONE_CYC || run_q == SLOW_DONE_CYC)
    else $error("busy run length wrong");
  AST_RESET_ADDR: assert property (
    usb_bus_reset |=> active_address == BUS_RESET_ADDR && device_enabled)
    else $error("bus reset address wrong");
  AST_RESET_EP: assert property (usb_bus_reset |=> !any_en)
    else $error("endpoint still enabled");
  AST_ADDR_HOLD: assert property (
    !zlp_acked && !usb_bus_reset |=>
    $stable({device_enabled, active_address}))
    else $error("address changed without cause");
  AST_DEBUG_IRQ: assert property (s_debug_event |=> debug_irq)
    else $error("debug interrupt missing");
  AST_DEBUG_CAUSE: assert property (debug_irq |->
    $past(mode_bits[MODE_DEBUG_BIT]) &&
    ($past(nak_event) || $past(error_event)))
    else $error("debug interrupt without cause");
  AST_MODE_WRITE: assert property (
    $changed(mode_bits) |-> $past(wr_strobe))
    else $error("mode changed without write");
  AST_EP_WRITE: assert property ($changed(ep_setup_flat) |->
    $past(wr_strobe) || $past(usb_bus_reset))
    else $error("endpoint setup changed without cause");
  AST_LOCK: assert property (lock_request |=> write_locked)
    else $error("lock not taken");
endmodule

bind ucd_command_decoder ucd_properties ucd_properties_i (
  .core_clk, .rst, .wr_strobe, .bus_wide, .usb_bus_reset, .zlp_acked,
  .lock_request, .nak_event, .error_event, .ep_setup_flat, .active_address,
  .device_enabled, .mode_bits, .setup_ack, .cmd_busy, .debug_irq,
  .write_locked
);

// ---- bench/ucd_host_model.sv ----
// Controller-side model that drives the command and data strobes.
module ucd_host_model (
  input wire logic core_clk,
  input wire logic cmd_busy,
  output logic cmd_strobe,
  output logic wr_strobe,
  output logic rd_strobe,
  output logic [15:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {cmd_strobe, wr_strobe, rd_strobe} = 3'h0;
    data_in = 16'h0000;
  end
  // One bus cycle: kind 0 command, 1 data write, 2 data read.
  task automatic strobe(input int kind, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge core_clk);
    // A slow command must finish before anything else is sent.
    while (cmd_busy === 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    data_in = d;
    @(negedge core_clk);
    cmd_strobe = kind == 0;
    wr_strobe = kind == 1;
    rd_strobe = kind == 2;
    repeat (3) @(negedge core_clk);
    {cmd_strobe, wr_strobe, rd_strobe} = 3'h0;
    // A released bus never keeps showing the last value.
    data_in = ~d;
    repeat (3) @(negedge core_clk);
  endtask
endmodule

// ---- bench/tb_ucd_command_decoder.sv ----
// Self-checking bench for the USB device command decoder.
module tb_ucd_command_decoder
  import ucd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic bus_wide, usb_bus_reset, zlp_acked, lock_request, nak_event;
  logic error_event, cmd_strobe, wr_strobe, rd_strobe, device_enabled;
  logic alloc_start, fifo_invalidate, setup_ack, cmd_busy, debug_irq;
  logic write_locked;
  logic [15:0] data_in, data_out, scr_m;
  logic [127:0] ep_status_flat, err_code_flat, ep_setup_flat;
  logic [10:0] frame_number;
  logic [31:0] irq_flags, v;
  logic [6:0] active_address;
  logic [7:0] mode_bits;
  logic [7:0] exp_q[$];
  logic [7:0] ep_m[16];
  int n_fail = 0;
  int n_compared = 0;
  int seed = 34399;
  int n_alloc = 0;
  int n_inval = 0;
  int n_ack = 0;
  int n_dbg = 0;
  int k0;

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    n_alloc += alloc_start === 1'b1;
    n_inval += fifo_invalidate === 1'b1;
    n_ack += setup_ack === 1'b1;
    n_dbg += debug_irq === 1'b1;
  end

  ucd_command_decoder ucd_command_decoder_i (
    .core_clk, .rst, .cmd_strobe, .wr_strobe, .rd_strobe, .data_in,
    .bus_wide, .usb_bus_reset, .zlp_acked, .lock_request, .nak_event,
    .error_event, .ep_status_flat, .err_code_flat, .frame_number,
    .irq_flags, .data_out, .ep_setup_flat, .active_address,
    .device_enabled, .mode_bits, .alloc_start, .fifo_invalidate,
    .setup_ack, .cmd_busy, .debug_irq, .write_locked
  );
  ucd_host_model ucd_host_model_i (
    .core_clk, .cmd_busy, .cmd_strobe, .wr_strobe, .rd_strobe, .data_in
  );

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic push(input logic [31:0] x, input int n);
    for (int k = 0; k < n; k++)
      exp_q.push_back(x[8*k+:8]);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask

  // Upper bytes of codes and of one-byte data carry junk on purpose.
  task automatic wr_cmd(input logic [7:0] code, input int n, logic [31:0] x);
    logic [15:0] d;
    ucd_host_model_i.strobe(0, {8'($random(seed)), code});
    for (int k = 0; k < (bus_wide ? (n + 1) / 2 : n); k++)
    begin
      d = 16'($random(seed));
      if (bus_wide)
        d = n == 1 ? {d[15:8], x[7:0]} : x[16*k+:16];
      else
        d[7:0] = x[8*k+:8];
      ucd_host_model_i.strobe(1, d);
    end
  endtask

  task automatic rd_cmd(input string what, input logic [7:0] code, int n);
    logic [15:0] e;
    ucd_host_model_i.strobe(0, {8'($random(seed)), code});
    for (int k = 0; k < (bus_wide ? (n + 1) / 2 : n); k++)
    begin
      if (k > 0)
        ucd_host_model_i.strobe(2, 16'($random(seed)));
      e = {8'h00, exp_q.pop_front()};
      if (bus_wide && exp_q.size() > 0)
        e[15:8] = exp_q.pop_front();
      check(what, data_out, e);
    end
  endtask

  task automatic scratch_rw(input bit takes);
    v = $random(seed);
    wr_cmd(CMD_SCRATCH_WR, 2, v);
    if (takes)
      scr_m = v[15:0];
    push(scr_m, 2);
    rd_cmd("scratch", CMD_SCRATCH_RD, 2);
  endtask

  initial
  begin
    #(30000 * 40);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    {bus_wide, usb_bus_reset, zlp_acked, lock_request} = 4'h0;
    {nak_event, error_event} = 2'h0;
    ep_status_flat = {$random(seed), $random(seed),
      $random(seed), $random(seed)};
    err_code_flat = {$random(seed), $random(seed),
      $random(seed), $random(seed)};
    frame_number = 11'($random(seed));
    irq_flags = $random(seed);
    scr_m = SCRATCH_RST;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    check("ep_rst", {31'h0, |ep_setup_flat}, 0);
    push(ADDR_RST, 1);
    rd_cmd("addr_rst", CMD_ADDR_RD, 1);
    for (int m = 0; m < 2; m++)
    begin
      bus_wide = m[0];
      for (int i = 0; i < 16; i++)
      begin
        push(ep_status_flat[8*i+:8], 1);
        rd_cmd("status", 8'(CMD_STATUS_IMG + i), 1);
        push(err_code_flat[8*i+:8], 1);
        rd_cmd("errcode", 8'(CMD_ERRCODE + i), 1);
      end
      scratch_rw(1);
      push({21'h0, frame_number}, 2);
      rd_cmd("frame", CMD_FRAME_RD, 2);
      push(irq_flags, 4);
      rd_cmd("irq", CMD_INT_RD, 4);
    end
    bus_wide = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      ep_m[i] = i < 2 ? {1'b1, i[0], 6'h00} : 8'($random(seed));
      if (i == 15)
        check("alloc_early", n_alloc, 0);
      wr_cmd(8'(CMD_EPCFG_WR + i), 1, {24'h0, ep_m[i]});
    end
    check("alloc", n_alloc, 1);
    for (int i = 0; i < 16; i++)
    begin
      check("setup_out", ep_setup_flat[8*i+:8], ep_m[i]);
      push(ep_m[i], 1);
      rd_cmd("setup_rd", 8'(CMD_EPCFG_RD + i), 1);
    end
    k0 = n_inval;
    ep_m[3] ^= 8'h20;
    wr_cmd(8'(CMD_EPCFG_WR + 3), 1, {24'h0, ep_m[3]});
    check("inval_none", n_inval, k0);
    ep_m[3] ^= 8'h01;
    wr_cmd(8'(CMD_EPCFG_WR + 3), 1, {24'h0, ep_m[3]});
    check("inval_size", n_inval, k0 + 1);
    wr_cmd(CMD_ADDR_WR, 1, 32'h85);
    check("addr_wait", {device_enabled, active_address}, 0);
    pulse(usb_bus_reset);
    check("bus_rst_addr", {device_enabled, active_address}, 8'h80);
    for (int i = 0; i < 16; i++)
      check("bus_rst_ep", ep_setup_flat[8*i+:8], ep_m[i] & 8'h7f);
    push(8'h85, 1);
    rd_cmd("addr_kept", CMD_ADDR_RD, 1);
    // A bus reset drops a pending address, so the controller writes it again.
    wr_cmd(CMD_ADDR_WR, 1, 32'h85);
    pulse(zlp_acked);
    check("addr_new", {device_enabled, active_address}, 8'h85);
    bus_wide = 1'b1;
    wr_cmd(CMD_MODE_WR, 1, 32'h04);
    push(8'h04, 1);
    rd_cmd("mode", CMD_MODE_RD, 1);
    pulse(nak_event);
    pulse(error_event);
    check("debug_irq", n_dbg, 2);
    wr_cmd(CMD_MODE_WR, 1, 32'h00);
    pulse(nak_event);
    check("debug_quiet", n_dbg, 2);
    bus_wide = 1'b0;
    wr_cmd(CMD_SETUP_ACK, 0, 0);
    check("setup_ack", n_ack, 1);
    wr_cmd(8'(CMD_VALIDATE + 1), 0, 0);
    check("slow_busy", cmd_busy, 1);
    bus_wide = 1'b1;
    wr_cmd(CMD_CLEAR, 0, 0);
    check("fast_busy", cmd_busy, 0);
    bus_wide = 1'b0;
    pulse(lock_request);
    check("locked", write_locked, 1);
    scratch_rw(0);
    wr_cmd(CMD_UNLOCK, 2, $random(seed));
    check("unlocked", write_locked, 0);
    scratch_rw(1);
    wr_cmd(CMD_MODE_WR, 1, 32'h04);
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    check("mode_rst", mode_bits, MODE_RST);
    print_verdict();
  end
endmodule
